// File: pfi_flow_ctrl.sv
// Operation
// - Eight return stack entries; pushing past eight overwrites saved contents.
// - Interrupt entry, calls and table reads push the return address.
// - Three-bit depth pointer follows nesting; an operation copies it out.
// - Interrupt entry saves data pointer, carry, skip, A and B once.
// - Skip flag is saved on interrupt so a pending skip survives.
// - Counter advances by instruction length; flow operations load targets.
// - Counter is page field above bit 6 and in-page offset below.
// - Passing offset 127 wraps to 0 and moves to the next page.
// - Data pointer holds group, file and digit; digit picks port bit.
// - Group field undefined after reset; software reloads the data pointer.
// - Program words are 10 bits in pages of 128 words.
// - Interrupts vector into the lower half of page 1.
// - Page 2 call reaches page 2 from anywhere with one word.
// - Table read returns all 10 bits of any program word in pages 0-95.
// - Table reads use pages 0-63, or 64-95 after upper bank select.
// - RAM words are 4 bits; bit set, clear and test work everywhere.
// - Interrupt needs request flag, its enable bit and global gate.
// - Gate set and clear operations; taking an interrupt clears it.
// - Enable bit chooses interrupt service or skip testing of the flag.
// - Flags set even when disabled and hold until serviced or tested.
// - Voltage drop flag cannot clear while its condition persists.
// - Priority external, timer 1, timer 2 at page 1 vectors 0, 4, 6.
// - Enable one allows interrupt and voids skip; zero does the opposite.
// - Interrupt entry clears only the serviced source's request flag.
// - Each stack entry is 14 bits wide, a full counter value.
module pfi_flow_ctrl
    import pfi_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic opValid,
    input pfi_op_t opCode,
    input wire logic [1:0] opLen,
    input wire logic [PC_W-1:0] opTarget,
    input wire logic [1:0] opBit,
    input wire logic [DP_W-1:0] opDp,
    output logic opReady,
    input wire logic [3:0] accIn,
    input wire logic [3:0] bIn,
    input wire logic carryIn,
    output logic [PC_W-1:0] programCounter,
    output logic [PC_W-1:0] romAddr,
    output logic romRd,
    input wire logic [ROM_W-1:0] romData,
    output logic [ROM_W-1:0] tableData,
    output logic tableValid,
    output logic [3:0] accOut,
    output logic accValid,
    output logic restoreValid,
    output logic [3:0] restoreAcc,
    output logic [3:0] restoreB,
    output logic restoreCarry,
    output logic [DP_W-1:0] dataPointer,
    input wire logic [RAM_W-1:0] ramRdata,
    output logic ramWe,
    output logic [RAM_W-1:0] ramWdata,
    input wire logic [PORTD_W-1:0] portdPin,
    output logic [PORTD_W-1:0] portdOut,
    input wire logic evExt,
    input wire logic evTimer1,
    input wire logic evTimer2,
    input wire logic voltageDropCond,
    output logic irqTaken,
    output logic skipFlag,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [REG_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [REG_DW-1:0] regRdata
);
    logic rstMeta, rstN;
    logic [PORTD_W-1:0] portdMeta, portdSync;
    pfi_state_t state;
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [SP_W-1:0] sp, spInc, spDec;
    logic gate, gateArm, bankUpper;
    logic [3:0] enOne, enTwo;
    logic [NUM_FLAGS-1:0] reqFlag, srcEn, irqHit, irqClr, setVec, clrVec;
    logic [OFS_W-1:0] irqVec;
    logic irqTake, stepOk, exec, push, pop, flagSkip, testSkip;
    logic [PC_W-1:0] pcSeq, pushVal;
    logic [PAGE_W-1:0] tablePage;
    logic [DP_W-1:0] saveDp;
    logic [3:0] saveAcc, saveB;
    logic saveCarry, saveSkip;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            portdMeta <= PORTD_RST;
            portdSync <= PORTD_RST;
        end else begin
            portdMeta <= portdPin;
            portdSync <= portdMeta;
        end
    end

    // Source enables: the voltage drop flag is only ever tested, never serviced.
    assign srcEn = {1'b0, enOne[EN_T2_BIT], enOne[EN_T1_BIT], enOne[EN_EXT_BIT]};
    assign irqHit = reqFlag & srcEn;
    assign irqTake = (state == ST_RUN) && gate && (|irqHit);
    assign opReady = (state == ST_RUN) && !irqTake;
    assign stepOk = opValid && opReady;
    // A pending skip swallows the accepted operation and only advances the counter.
    assign exec = stepOk && !skipFlag;
    assign pcSeq = programCounter + {12'h000, opLen};
    assign spInc = sp + 3'h1;
    assign spDec = sp - 3'h1;

    always_comb begin
        irqClr = '0;
        irqVec = VEC_EXT;
        if (irqHit[SRC_EXT]) begin
            irqClr[SRC_EXT] = irqTake;
            irqVec = VEC_EXT;
        end else if (irqHit[SRC_T1]) begin
            irqClr[SRC_T1] = irqTake;
            irqVec = VEC_T1;
        end else if (irqHit[SRC_T2]) begin
            irqClr[SRC_T2] = irqTake;
            irqVec = VEC_T2;
        end
    end

    assign push = irqTake || (exec && (opCode == OP_CALL || opCode == OP_PAGE2_CALL
        || opCode == OP_TABLE_READ));
    assign pushVal = irqTake ? programCounter : pcSeq;
    assign pop = (exec && (opCode == OP_RETURN || opCode == OP_RETURN_IRQ))
        || (state == ST_TABLE);

    // Table reads map the page operand onto the selected bank.
    assign tablePage = bankUpper ? UPPER_BANK_BASE + {2'h0, opTarget[OFS_W+4:OFS_W]}
        : {1'b0, opTarget[OFS_W+5:OFS_W]};

    assign flagSkip = exec && (opCode == OP_FLAG_TEST) && !srcEn[opBit]
        && reqFlag[opBit];
    assign testSkip = flagSkip
        || (exec && opCode == OP_RAM_TEST && !ramRdata[opBit])
        || (exec && opCode == OP_PORTD_TEST && !portdSync[dataPointer[2:0]]);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            programCounter <= PC_RST;
        end else if (irqTake) begin
            programCounter <= {IRQ_PAGE, irqVec};
        end else if (pop) begin
            programCounter <= stack[spDec];
        end else if (exec) begin
            case (opCode)
                OP_BRANCH, OP_CALL: programCounter <= opTarget;
                OP_PAGE2_CALL: programCounter <= {PAGE2, opTarget[OFS_W-1:0]};
                OP_TABLE_READ: programCounter <= programCounter;
                default: programCounter <= pcSeq;
            endcase
        end else if (stepOk) begin
            programCounter <= pcSeq;
        end
    end

    // Writing past the eighth entry wraps the pointer onto the oldest entry.
    generate
        for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
            always_ff @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    stack[i] <= PC_RST;
                end else if (push && sp == 3'(i)) begin
                    stack[i] <= pushVal;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            sp <= SP_RST;
        end else if (push) begin
            sp <= spInc;
        end else if (pop) begin
            sp <= spDec;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state <= ST_RUN;
            romAddr <= PC_RST;
            romRd <= 1'b0;
            tableData <= '0;
            tableValid <= 1'b0;
        end else begin
            tableValid <= 1'b0;
            romRd <= 1'b0;
            unique case (state)
                ST_RUN: begin
                    if (exec && opCode == OP_TABLE_READ) begin
                        romAddr <= {tablePage, opTarget[OFS_W-1:0]};
                        romRd <= 1'b1;
                        state <= ST_TABLE;
                    end
                end
                ST_TABLE: begin
                    tableData <= romData;
                    tableValid <= 1'b1;
                    state <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            bankUpper <= 1'b0;
        end else if (exec && opCode == OP_BANK_UPPER) begin
            bankUpper <= 1'b1;
        end else if (exec && opCode == OP_BANK_LOWER) begin
            bankUpper <= 1'b0;
        end
    end

    // A gate set takes effect only after the following instruction completes.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            gate <= 1'b0;
            gateArm <= 1'b0;
        end else if (irqTake) begin
            gate <= 1'b0;
            gateArm <= 1'b0;
        end else if (exec && opCode == OP_GATE_CLEAR) begin
            gate <= 1'b0;
            gateArm <= 1'b0;
        end else if (stepOk && gateArm) begin
            gate <= 1'b1;
            gateArm <= 1'b0;
        end else if (exec && opCode == OP_GATE_SET) begin
            gateArm <= 1'b1;
        end
    end

    assign setVec = {voltageDropCond, evTimer2, evTimer1, evExt};

    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            if (i == SRC_VDROP) begin : g_vd
                assign clrVec[i] = flagSkip && opBit == 2'(i) && !voltageDropCond;
            end else begin : g_irq
                assign clrVec[i] = irqClr[i] || (flagSkip && opBit == 2'(i));
            end
            always_ff @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    reqFlag[i] <= 1'b0;
                end else begin
                    reqFlag[i] <= setVec[i] || (reqFlag[i] && !clrVec[i]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            skipFlag <= 1'b0;
        end else if (irqTake) begin
            skipFlag <= 1'b0;
        end else if (exec && opCode == OP_RETURN_IRQ) begin
            skipFlag <= saveSkip;
        end else if (testSkip) begin
            skipFlag <= 1'b1;
        end else if (stepOk) begin
            skipFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            saveDp <= DP_RST;
            saveAcc <= 4'h0;
            saveB <= 4'h0;
            saveCarry <= 1'b0;
            saveSkip <= 1'b0;
        end else if (irqTake) begin
            saveDp <= dataPointer;
            saveAcc <= accIn;
            saveB <= bIn;
            saveCarry <= carryIn;
            saveSkip <= skipFlag;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            restoreValid <= 1'b0;
            restoreAcc <= 4'h0;
            restoreB <= 4'h0;
            restoreCarry <= 1'b0;
        end else begin
            restoreValid <= exec && opCode == OP_RETURN_IRQ;
            if (exec && opCode == OP_RETURN_IRQ) begin
                restoreAcc <= saveAcc;
                restoreB <= saveB;
                restoreCarry <= saveCarry;
            end
        end
    end

    // The group field is cleared here but software must not rely on it.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dataPointer <= DP_RST;
        end else if (exec && opCode == OP_RETURN_IRQ) begin
            dataPointer <= saveDp;
        end else if (exec && opCode == OP_LOAD_DP) begin
            dataPointer <= opDp;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ramWe <= 1'b0;
            ramWdata <= 4'h0;
            portdOut <= PORTD_RST;
        end else begin
            ramWe <= exec && (opCode == OP_RAM_SET || opCode == OP_RAM_CLEAR);
            if (exec && opCode == OP_RAM_SET) begin
                ramWdata <= ramRdata | (4'h1 << opBit);
            end else if (exec && opCode == OP_RAM_CLEAR) begin
                ramWdata <= ramRdata & ~(4'h1 << opBit);
            end
            if (exec && opCode == OP_PORTD_SET) begin
                portdOut[dataPointer[DP_Y_LSB+2:DP_Y_LSB]] <= 1'b1;
            end else if (exec && opCode == OP_PORTD_CLEAR) begin
                portdOut[dataPointer[DP_Y_LSB+2:DP_Y_LSB]] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            accOut <= 4'h0;
            accValid <= 1'b0;
            irqTaken <= 1'b0;
        end else begin
            accValid <= exec && opCode == OP_READ_DEPTH;
            irqTaken <= irqTake;
            if (exec && opCode == OP_READ_DEPTH) begin
                accOut <= {1'b0, sp};
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            enOne <= EN_RST;
            enTwo <= EN_RST;
        end else if (regWr && regAddr == REG_EN_ONE) begin
            enOne <= regWdata[3:0];
        end else if (regWr && regAddr == REG_EN_TWO) begin
            enTwo <= regWdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regRdata <= '0;
        end else if (regRd) begin
            case (regAddr)
                REG_PC: regRdata <= {2'h0, programCounter};
                REG_STATUS: regRdata <= {9'h000, skipFlag, bankUpper, gateArm, gate, sp};
                REG_EN_ONE: regRdata <= {12'h000, enOne};
                REG_EN_TWO: regRdata <= {12'h000, enTwo};
                REG_FLAGS: regRdata <= {12'h000, reqFlag};
                REG_TABLE: regRdata <= {6'h00, tableData};
                REG_DPTR: regRdata <= {6'h00, dataPointer};
                default: regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    sequence tableStart;
        exec && opCode == OP_TABLE_READ;
    endsequence
    sequence tableFetch;
        romRd && state == ST_TABLE ##1 tableValid && tableData == $past(romData);
    endsequence

    table_fetch_a: assert property (tableStart |=> tableFetch)
        else $error("table read did not return the program word");
    stack_push_a: assert property (exec && opCode == OP_CALL
        |=> sp == $past(spInc) && stack[$past(sp)] == $past(pcSeq))
        else $error("call did not push the return address");
    page_wrap_a: assert property (exec && opCode == OP_NEXT && opLen == 2'h1
        && programCounter[OFS_W-1:0] == 7'h7F |=> programCounter[OFS_W-1:0] == 7'h00
        && programCounter[PC_W-1:OFS_W] == $past(programCounter[PC_W-1:OFS_W]) + 7'h01)
        else $error("offset 127 did not wrap into the next page");
    irq_vector_a: assert property (irqTake && irqHit[SRC_T1] && !irqHit[SRC_EXT]
        |=> programCounter == {IRQ_PAGE, VEC_T1} && !gate)
        else $error("timer 1 vector or gate clear wrong");
    irq_cond_a: assert property (irqTake |-> gate
        && ((reqFlag[SRC_EXT] && enOne[EN_EXT_BIT]) || (reqFlag[SRC_T1] && enOne[EN_T1_BIT])
        || (reqFlag[SRC_T2] && enOne[EN_T2_BIT])))
        else $error("interrupt taken without all three conditions");
    lower_pending_a: assert property (irqTake && irqHit[SRC_EXT] && reqFlag[SRC_T1]
        |=> (!reqFlag[SRC_EXT] || $past(evExt)) && reqFlag[SRC_T1])
        else $error("lower priority flag lost on interrupt entry");
    vdrop_hold_a: assert property (reqFlag[SRC_VDROP] && voltageDropCond
        |=> reqFlag[SRC_VDROP])
        else $error("voltage drop flag cleared while condition holds");
    flag_set_a: assert property ($rose(evTimer2) && !gate |=> reqFlag[SRC_T2])
        else $error("request flag did not set while disabled");
    skip_save_a: assert property (irqTake |=> saveSkip == $past(skipFlag) && !skipFlag)
        else $error("skip flag not saved on interrupt entry");
    depth_read_a: assert property (exec && opCode == OP_READ_DEPTH
        |=> accValid && accOut == {1'b0, $past(sp)})
        else $error("depth pointer read wrong");
endmodule

// File: pfi_flow_ctrl_tb_top.sv
module pfi_flow_ctrl_tb_top import pfi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, arst_n = 1'b0, opValid = 1'b0, carryIn = 1'b0, regWr = 1'b0;
    logic regRd = 1'b0, evExt = 1'b0, evTimer1 = 1'b0, evTimer2 = 1'b0;
    pfi_op_t opCode = OP_NEXT;
    logic [1:0] opLen = 2'h1, opBit = 2'h0, l;
    logic [PC_W-1:0] opTarget = 14'h0000, t, ea, pc, stk [STACK_DEPTH];
    logic [DP_W-1:0] opDp = 10'h000, dataPointer;
    logic [3:0] accIn = 4'h0, bIn = 4'h0, accOut, restoreAcc, restoreB, ramWdata, ramRdata;
    logic [REG_AW-1:0] regAddr = 4'h0;
    logic [REG_DW-1:0] regWdata = 16'h0000, regRdata;
    logic opReady, romRd, tableValid, accValid, restoreValid, restoreCarry, ramWe;
    logic irqTaken, skipFlag, up, vdropCond = 1'b0;
    logic [PC_W-1:0] programCounter, romAddr;
    logic [ROM_W-1:0] romData, tableData;
    logic [PORTD_W-1:0] portdOut;
    logic [SP_W-1:0] sp;
    logic [15:0] rv;
    logic [31:0] seed = 32'h0000E423, v;
    int err_count = 0, n_tests = 0, cyc = 0;
    assign romData = romAddr[9:0] ^ 10'h2A5;
    assign ramRdata = dataPointer[3:0];
    pfi_flow_ctrl u_dut (.clk(clk), .arst_n(arst_n), .opValid(opValid), .opCode(opCode),
        .opLen(opLen), .opTarget(opTarget), .opBit(opBit), .opDp(opDp), .opReady(opReady),
        .accIn(accIn), .bIn(bIn), .carryIn(carryIn), .programCounter(programCounter),
        .romAddr(romAddr), .romRd(romRd), .romData(romData), .tableData(tableData),
        .tableValid(tableValid), .accOut(accOut), .accValid(accValid),
        .restoreValid(restoreValid), .restoreAcc(restoreAcc), .restoreB(restoreB),
        .restoreCarry(restoreCarry), .dataPointer(dataPointer), .ramRdata(ramRdata),
        .ramWe(ramWe), .ramWdata(ramWdata), .portdPin(8'h00), .portdOut(portdOut),
        .evExt(evExt), .evTimer1(evTimer1), .evTimer2(evTimer2), .voltageDropCond(vdropCond),
        .irqTaken(irqTaken), .skipFlag(skipFlag), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Holds the request until the edge where opReady is high; effects are then visible.
    task automatic op(input pfi_op_t c, input logic [1:0] ln, input logic [PC_W-1:0] tg);
        opValid <= 1'b1;
        opCode <= c;
        opLen <= ln;
        opTarget <= tg;
        #1;
        while (opReady !== 1'b1) step();
        step();
    endtask
    task automatic wr(input logic [REG_AW-1:0] a, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        step();
        regWr <= 1'b0;
        step();
    endtask
    task automatic rd(input logic [REG_AW-1:0] a, output logic [15:0] d);
        regRd <= 1'b1;
        regAddr <= a;
        step();
        regRd <= 1'b0;
        d = regRdata;
        step();
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) step();
        rd(REG_PC, rv); chk("pc_reset", rv, 16'h0000);
        rd(REG_STATUS, rv); chk("status_reset", rv, 16'h0000);
        rd(REG_EN_ONE, rv); chk("en_reset", rv, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            wr(REG_EN_ONE, {12'h000, v[3:0]});
            wr(REG_EN_TWO, {12'h000, v[7:4]});
            wr(REG_PC, 16'h3FFF);
            wr(4'hF, 16'hFFFF);
            rd(REG_EN_ONE, rv); chk("en_one", rv, {12'h000, v[3:0]});
            rd(REG_EN_TWO, rv); chk("en_two", rv, {12'h000, v[7:4]});
            rd(REG_PC, rv); chk("pc_ro", rv, 16'h0000);
            rd(4'hF, rv); chk("unmapped", rv, 16'h0000);
        end
        wr(REG_EN_ONE, 16'h0000);
        $display("test registers done");
        pc = PC_RST;
        sp = SP_RST;
        up = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i == 3 || i == 6) begin
                op(i == 3 ? OP_BANK_UPPER : OP_BANK_LOWER, 2'h1, 14'h0000);
                pc = pc + 14'h0001;
                up = (i == 3);
            end
            v = rnd();
            t = v[13:0];
            ea = up ? {7'h40 + {2'h0, t[11:7]}, t[6:0]} : {1'b0, t[12:7], t[6:0]};
            op(OP_TABLE_READ, 2'h1, t);
            chk("rom_rd", {15'h0000, romRd}, 16'h0001);
            chk("rom_addr", {2'h0, romAddr}, {2'h0, ea});
            chk("busy", {15'h0000, opReady}, 16'h0000);
            step();
            pc = pc + 14'h0001;
            chk("table_valid", {15'h0000, tableValid}, 16'h0001);
            chk("table_data", {6'h00, tableData}, {6'h00, ea[9:0] ^ 10'h2A5});
            chk("table_ret", {2'h0, programCounter}, {2'h0, pc});
        end
        for (int i = 0; i < 40; i++) begin
            v = rnd();
            l = (v[1:0] == 2'h0 || i % 10 == 1) ? 2'h1 : v[1:0];
            if (i % 10 == 0) begin
                pc = {v[13:7], 7'h7F};
                op(OP_BRANCH, 2'h1, pc);
            end else begin
                op(OP_NEXT, l, 14'h0000);
                pc = pc + {12'h000, l};
            end
            chk("seq_pc", {2'h0, programCounter}, {2'h0, pc});
        end
        $display("test sequencing done");
        for (int i = 0; i < 9; i++) begin
            v = rnd();
            t = (i == 4) ? {PAGE2, v[6:0]} : v[13:0];
            stk[sp] = pc + 14'h0001;
            sp = sp + 3'h1;
            op(i == 4 ? OP_PAGE2_CALL : OP_CALL, 2'h1, t);
            pc = t;
            chk("call_pc", {2'h0, programCounter}, {2'h0, pc});
            op(OP_READ_DEPTH, 2'h1, 14'h0000);
            pc = pc + 14'h0001;
            chk("depth_valid", {15'h0000, accValid}, 16'h0001);
            chk("depth", {12'h000, accOut}, {12'h000, 1'b0, sp});
        end
        for (int i = 0; i < 9; i++) begin
            sp = sp - 3'h1;
            pc = stk[sp];
            op(OP_RETURN, 2'h1, 14'h0000);
            chk("ret_pc", {2'h0, programCounter}, {2'h0, pc});
        end
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            opDp <= v[9:0];
            opBit <= v[11:10];
            op(OP_LOAD_DP, 2'h1, 14'h0000);
            chk("dptr", {6'h00, dataPointer}, {6'h00, v[9:0]});
            op(OP_RAM_SET, 2'h1, 14'h0000);
            chk("ram_we", {15'h0000, ramWe}, 16'h0001);
            chk("ram_set", {12'h000, ramWdata}, {12'h000, v[3:0] | (4'h1 << v[11:10])});
            op(OP_RAM_CLEAR, 2'h1, 14'h0000);
            chk("ram_clr", {12'h000, ramWdata}, {12'h000, v[3:0] & ~(4'h1 << v[11:10])});
            op(OP_PORTD_SET, 2'h1, 14'h0000);
            chk("portd", {15'h0000, portdOut[v[2:0]]}, 16'h0001);
            pc = pc + 14'h0004;
        end
        opValid <= 1'b0;
        $display("test stack and data done");
        wr(REG_EN_ONE, 16'h000D);
        evExt <= 1'b1; evTimer1 <= 1'b1; evTimer2 <= 1'b1;
        step();
        evExt <= 1'b0; evTimer1 <= 1'b0; evTimer2 <= 1'b0;
        step();
        rd(REG_FLAGS, rv); chk("flags_pend", rv, 16'h0007);
        for (int s = 0; s < 3; s++) begin
            v = rnd();
            accIn <= v[3:0]; bIn <= v[7:4]; carryIn <= v[8];
            op(OP_GATE_SET, 2'h1, 14'h0000);
            op(OP_NEXT, 2'h1, 14'h0000);
            opValid <= 1'b0;
            pc = pc + 14'h0002;
            for (int k = 0; k < 20 && irqTaken !== 1'b1; k++) step();
            chk("irq_taken", {15'h0000, irqTaken}, 16'h0001);
            stk[sp] = pc;
            sp = sp + 3'h1;
            pc = {IRQ_PAGE, s == 0 ? VEC_EXT : s == 1 ? VEC_T1 : VEC_T2};
            chk("vector", {2'h0, programCounter}, {2'h0, pc});
            rd(REG_FLAGS, rv); chk("flags_left", rv, 16'h0007 & ~((16'h0002 << s) - 16'h0001));
            rd(REG_STATUS, rv); chk("gate_sp", {12'h000, rv[3:0]}, {12'h000, 1'b0, sp});
            accIn <= ~v[3:0]; bIn <= ~v[7:4]; carryIn <= ~v[8];
            sp = sp - 3'h1;
            pc = stk[sp];
            op(OP_RETURN_IRQ, 2'h1, 14'h0000);
            chk("reti_pc", {2'h0, programCounter}, {2'h0, pc});
            chk("rst_valid", {15'h0000, restoreValid}, 16'h0001);
            chk("rst_ab", {7'h00, restoreCarry, restoreB, restoreAcc}, {7'h00, v[8:0]});
        end
        opValid <= 1'b0;
        wr(REG_EN_ONE, 16'h0000);
        evTimer1 <= 1'b1;
        step();
        evTimer1 <= 1'b0;
        op(OP_GATE_SET, 2'h1, 14'h0000);
        op(OP_NEXT, 2'h1, 14'h0000);
        opValid <= 1'b0;
        pc = pc + 14'h0002;
        repeat (6) step();
        rd(REG_STATUS, rv); chk("gate_held", {15'h0000, rv[3]}, 16'h0001);
        opBit <= SRC_T1[1:0];
        op(OP_FLAG_TEST, 2'h1, 14'h0000);
        chk("skip_set", {15'h0000, skipFlag}, 16'h0001);
        op(OP_NEXT, 2'h2, 14'h0000);
        opValid <= 1'b0;
        pc = pc + 14'h0003;
        chk("skip_clr", {15'h0000, skipFlag}, 16'h0000);
        chk("skip_pc", {2'h0, programCounter}, {2'h0, pc});
        rd(REG_FLAGS, rv); chk("flag_tested", rv, 16'h0000);
        vdropCond <= 1'b1;
        opBit <= 2'h3;
        for (int i = 0; i < 2; i++) begin
            step();
            op(OP_FLAG_TEST, 2'h1, 14'h0000);
            op(OP_NEXT, 2'h1, 14'h0000);
            opValid <= 1'b0;
            vdropCond <= 1'b0;
            rd(REG_FLAGS, rv); chk("vdrop_flag", rv, i == 0 ? 16'h0008 : 16'h0000);
        end
        $display("test interrupts done");
        summarize();
    end
endmodule

// File: pfi_pkg.sv
package pfi_pkg;
    localparam int PC_W = 14;
    localparam int OFS_W = 7;
    localparam int PAGE_W = 7;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int ROM_W = 10;
    localparam int RAM_W = 4;
    localparam int DP_W = 10;
    localparam int PORTD_W = 8;
    localparam int NUM_FLAGS = 4;
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;

    // Field positions inside the data pointer and the first enable register.
    localparam int DP_Y_LSB = 0;
    localparam int DP_X_LSB = 4;
    localparam int DP_Z_LSB = 8;
    localparam int EN_EXT_BIT = 0;
    localparam int EN_T1_BIT = 2;
    localparam int EN_T2_BIT = 3;

    // Request flag indices; also the source operand of the flag test.
    localparam int SRC_EXT = 0;
    localparam int SRC_T1 = 1;
    localparam int SRC_T2 = 2;
    localparam int SRC_VDROP = 3;

    localparam logic [PAGE_W-1:0] IRQ_PAGE = 7'h01;
    localparam logic [PAGE_W-1:0] PAGE2 = 7'h02;
    localparam logic [PAGE_W-1:0] UPPER_BANK_BASE = 7'h40;
    localparam logic [OFS_W-1:0] VEC_EXT = 7'h00;
    localparam logic [OFS_W-1:0] VEC_T1 = 7'h04;
    localparam logic [OFS_W-1:0] VEC_T2 = 7'h06;

    localparam logic [PC_W-1:0] PC_RST = 14'h0000;
    localparam logic [SP_W-1:0] SP_RST = 3'h0;
    localparam logic [DP_W-1:0] DP_RST = 10'h000;
    localparam logic [3:0] EN_RST = 4'h0;
    localparam logic [PORTD_W-1:0] PORTD_RST = 8'h00;

    localparam logic [REG_AW-1:0] REG_PC = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
    localparam logic [REG_AW-1:0] REG_EN_ONE = 4'h2;
    localparam logic [REG_AW-1:0] REG_EN_TWO = 4'h3;
    localparam logic [REG_AW-1:0] REG_FLAGS = 4'h4;
    localparam logic [REG_AW-1:0] REG_TABLE = 4'h5;
    localparam logic [REG_AW-1:0] REG_DPTR = 4'h6;

    typedef enum logic [4:0] {
        OP_NEXT, OP_BRANCH, OP_CALL, OP_PAGE2_CALL, OP_RETURN, OP_RETURN_IRQ,
        OP_TABLE_READ, OP_READ_DEPTH, OP_BANK_UPPER, OP_BANK_LOWER,
        OP_GATE_SET, OP_GATE_CLEAR, OP_LOAD_DP, OP_RAM_SET, OP_RAM_CLEAR,
        OP_RAM_TEST, OP_PORTD_SET, OP_PORTD_CLEAR, OP_PORTD_TEST, OP_FLAG_TEST
    } pfi_op_t;

    typedef enum logic {ST_RUN, ST_TABLE} pfi_state_t;
endpackage
